// File: sim/pwm_rssi_output_control_tb.sv
`timescale 1ns/100ps
module pwm_rssi_output_control_tb
  import pwm_out_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pwm, err;
  logic [31:0] rd;
  rx_packet_t rx;
  io_packet_t io;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 32'hBF961023;
  int hi, db, lv;
  logic [15:0] a;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] re [6] = '{32'h0, 32'h0, 32'hFF, 32'h28, 32'h0, 32'h0};
  always #12.5 i_sys_clk = ~i_sys_clk;
  pwm_rssi_output_control dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_rx_packet(rx), .i_io_packet(io), .o_second_pulse_output(pwm));
  remote_radio_model far (.i_sys_clk(i_sys_clk), .o_rx_packet(rx), .o_io_packet(io));
  // ----
  // Helpers
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic near(input int seen, input int exp, input int tol);
    check((seen >= exp - tol && seen <= exp + tol) ? exp : seen, exp);
  endtask : near
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One period to settle, one counted
  task automatic measure(input int n);
    repeat (n) @(posedge i_sys_clk);
    hi = 0;
    repeat (n) begin
      @(posedge i_sys_clk);
      hi += (pwm === 1'b1);
    end
  endtask : measure
  function automatic int sexp(input int d);
    int v;
    v = 2670 * (240 + 17 * d) / 1000;
    return (v > 2670) ? 2670 : v;
  endfunction : sexp
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ----
  // Sequence
  // ----
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      check(rd, re[i]);
    end
    apb(1'b0, 8'h3C, 32'h0);
    check(err, 1);
    apb(1'b1, 8'h00, 32'h3);
    check(err, 1);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 0);
    measure(2670);
    check(hi, 0);
    apb(1'b1, 8'h0C, 32'hFF);
    check(err, 0);
    apb(1'b1, 8'h00, 32'h1);
    measure(2670);
    check(hi, 0);
    for (int i = 0; i < 5; i++) begin
      db = (i < 3) ? 10 * (i + 1) : (i == 3) ? 60 : 10 + ($unsigned($random(seed)) % 21);
      far.send_rx(8'(db));
      measure(2670);
      near(hi, sexp(db), 27);
    end
    apb(1'b0, 8'h14, 32'h0);
    check(rd[10], 1'b1);
    apb(1'b1, 8'h00, 32'h2);
    for (int i = 0; i < 4; i++) begin
      lv = (i == 0) ? 0 : (i == 1) ? 32'h1FF : (i == 2) ? 32'h3FF : $random(seed) & 32'h3FF;
      apb(1'b1, 8'h04, 32'(lv));
      measure(2560);
      near(hi, lv * 2560 / 1023, 8);
    end
    a = 16'($random(seed));
    lv = $random(seed) & 32'h3FF;
    apb(1'b1, 8'h10, {16'h0, a});
    far.send_io(a, 1'b1, 10'(lv));
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'(lv));
    far.send_io(~a, 1'b1, ~10'(lv));
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'(lv));
    far.send_io(a, 1'b0, 10'h000);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'(lv));
    tally_and_finish();
  end
endmodule : pwm_rssi_output_control_tb

// File: sim/remote_radio_model.sv
`timescale 1ns/100ps
module remote_radio_model
  import pwm_out_pkg::*;
(
  input wire logic i_sys_clk,
  output rx_packet_t o_rx_packet,
  output io_packet_t o_io_packet
);
  initial begin
    o_rx_packet = '0;
    o_io_packet = '0;
  end
  // Fields scrambled between packets
  task automatic send_rx(input logic [7:0] db);
    @(posedge i_sys_clk);
    o_rx_packet <= '{1'b1, 16'h1234, db};
    @(posedge i_sys_clk);
    o_rx_packet <= '{1'b0, 16'hEDCB, ~db};
  endtask : send_rx
  task automatic send_io(input logic [15:0] a, input logic h, input logic [9:0] v);
    @(posedge i_sys_clk);
    o_io_packet <= '{1'b1, a, h, v};
    @(posedge i_sys_clk);
    o_io_packet <= '{1'b0, ~a, 1'b0, ~v};
  endtask : send_io
endmodule : remote_radio_model

// File: verilog/pwm_out_consts.svh
`ifndef PWM_OUT_CONSTS_SVH
`define PWM_OUT_CONSTS_SVH

// Register byte offsets
`define OFS_FUNC_SEL 8'h00
`define OFS_LEVEL 8'h04
`define OFS_PASS_TMO 8'h08
`define OFS_HOLD_TIME 8'h0C
`define OFS_SRC_ADDR 8'h10
`define OFS_STATUS 8'h14

// Reset values
`define RST_FUNC_SEL 2'h0
`define RST_LEVEL 10'h000
`define RST_PASS_TMO 8'hFF
`define RST_HOLD_TIME 8'h28
`define RST_SRC_ADDR 16'h0000

// Function select encodings
`define FUNC_DISABLED 2'h0
`define FUNC_STRENGTH 2'h1
`define FUNC_LEVEL 2'h2

// Timing
`define CLK_PERIOD_NS 25
`define TICK_MS 100
`define TICK_CYCLES ((`TICK_MS * 1000000) / `CLK_PERIOD_NS)
`define STEP_NS 144
`define STEP_CYCLES ((`STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRENGTH_STEPS 10'd445
`define LEVEL_PERIOD_NS 64000
`define LEVEL_PERIOD_CYCLES (`LEVEL_PERIOD_NS / `CLK_PERIOD_NS)
`define LEVEL_FULL 10'h3FF
`define HOLD_FOREVER 8'hFF

// Strength duty: 24 percent of 445 plus about 7.56 steps per dB
`define DUTY_FLOOR 10'd107
`define DUTY_PER_DB_X16 10'd121

`endif

// File: verilog/pwm_out_pkg.sv
package pwm_out_pkg;

  typedef struct packed {
    logic valid;
    logic [15:0] src_addr;
    logic [7:0] margin_db;
  } rx_packet_t;

  typedef struct packed {
    logic valid;
    logic [15:0] src_addr;
    logic has_second_analog;
    logic [9:0] second_analog_input;
  } io_packet_t;

endpackage : pwm_out_pkg

// File: verilog/pwm_rssi_output_control.sv
`timescale 1ns/100ps
`include "pwm_out_consts.svh"
module pwm_rssi_output_control
  import pwm_out_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire rx_packet_t i_rx_packet,
  input wire io_packet_t i_io_packet,
  output logic o_second_pulse_output
);

  typedef struct packed {
    logic [1:0] second_output_function_select;
    logic [9:0] second_output_level;
    logic [7:0] passed_level_timeout;
    logic [7:0] signal_strength_hold_time;
    logic [15:0] io_source_address_match;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [21:0] prescale;
    logic [7:0] pass_cnt;
    logic [7:0] hold_cnt;
    logic strength_live;
    logic [9:0] strength_duty;
    logic [2:0] step_div;
    logic [9:0] step_pos;
    logic [11:0] lvl_pos;
    logic pulse;
  } state_t;

  state_t cur;
  state_t nxt;
  logic tick;
  logic setup;
  logic access;
  logic [9:0] mapped;
  logic [11:0] lvl_thresh;

  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable && cur.pready;
  assign tick = (cur.prescale == 22'(`TICK_CYCLES - 1));

  // Strength margin to duty steps
  always_comb begin
    logic [17:0] raw;
    raw = 18'(`DUTY_FLOOR) + 18'((18'(i_rx_packet.margin_db) * 18'(`DUTY_PER_DB_X16)) >> 4);
    if (raw > 18'(`STRENGTH_STEPS)) begin
      mapped = `STRENGTH_STEPS;
    end else begin
      mapped = raw[9:0];
    end
  end

  // Level to level-period threshold
  always_comb begin
    logic [23:0] prod;
    prod = 24'(cur.second_output_level) * 24'(`LEVEL_PERIOD_CYCLES);
    lvl_thresh = 12'(prod / 24'(`LEVEL_FULL));
  end

  always_comb begin
    nxt = cur;
    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    nxt.pready = setup;
    nxt.pslverr = 1'b0;
    if (setup) begin
      nxt.prdata = 32'h0000_0000;
      case (i_paddr)
        `OFS_FUNC_SEL: nxt.prdata = {30'h0, cur.second_output_function_select};
        `OFS_LEVEL: nxt.prdata = {22'h0, cur.second_output_level};
        `OFS_PASS_TMO: nxt.prdata = {24'h0, cur.passed_level_timeout};
        `OFS_HOLD_TIME: nxt.prdata = {24'h0, cur.signal_strength_hold_time};
        `OFS_SRC_ADDR: nxt.prdata = {16'h0, cur.io_source_address_match};
        `OFS_STATUS: nxt.prdata = {21'h0, cur.strength_live, cur.strength_duty};
        default: nxt.pslverr = 1'b1;
      endcase
      if (i_pwrite && i_paddr == `OFS_FUNC_SEL && i_pwdata[1:0] > `FUNC_LEVEL) begin
        nxt.pslverr = 1'b1;
      end
    end
    // Writes land on the access edge, with pready seen
    if (access && i_pwrite) begin
      case (i_paddr)
        `OFS_FUNC_SEL: begin
          if (i_pwdata[1:0] <= `FUNC_LEVEL) begin
            nxt.second_output_function_select = i_pwdata[1:0];
          end
        end
        `OFS_LEVEL: nxt.second_output_level = i_pwdata[9:0];
        `OFS_PASS_TMO: nxt.passed_level_timeout = i_pwdata[7:0];
        `OFS_HOLD_TIME: nxt.signal_strength_hold_time = i_pwdata[7:0];
        `OFS_SRC_ADDR: nxt.io_source_address_match = i_pwdata[15:0];
        default: ;
      endcase
    end
    // ----------------------------------------
    // Timeouts
    // ----------------------------------------
    nxt.prescale = tick ? 22'h0 : cur.prescale + 22'h1;
    if (tick && cur.pass_cnt != 8'h00) begin
      nxt.pass_cnt = cur.pass_cnt - 8'h01;
      if (cur.pass_cnt == 8'h01) begin
        nxt.second_output_level = `RST_LEVEL;
      end
    end
    if (tick && cur.hold_cnt != 8'h00 && cur.signal_strength_hold_time != `HOLD_FOREVER) begin
      nxt.hold_cnt = cur.hold_cnt - 8'h01;
      if (cur.hold_cnt == 8'h01) begin
        nxt.strength_live = 1'b0;
      end
    end
    // ----------------------------------------
    // Packet arrivals win over timeouts and bus
    // ----------------------------------------
    if (i_io_packet.valid && i_io_packet.src_addr == cur.io_source_address_match) begin
      nxt.pass_cnt = cur.passed_level_timeout;
      if (i_io_packet.has_second_analog) begin
        nxt.second_output_level = i_io_packet.second_analog_input;
        if (i_io_packet.second_analog_input == 10'h000) begin
          nxt.pass_cnt = 8'h00;
        end
      end
    end
    if (i_rx_packet.valid) begin
      nxt.strength_live = 1'b1;
      nxt.strength_duty = mapped;
      nxt.hold_cnt = cur.signal_strength_hold_time;
    end
    // ----------------------------------------
    // Pulse generators
    // ----------------------------------------
    nxt.step_div = (cur.step_div == 3'(`STEP_CYCLES - 1)) ? 3'h0 : cur.step_div + 3'h1;
    if (cur.step_div == 3'(`STEP_CYCLES - 1)) begin
      nxt.step_pos = (cur.step_pos == `STRENGTH_STEPS - 10'd1) ? 10'h0 : cur.step_pos + 10'h1;
    end
    nxt.lvl_pos = (cur.lvl_pos == 12'(`LEVEL_PERIOD_CYCLES - 1)) ? 12'h0 : cur.lvl_pos + 12'h1;
    case (cur.second_output_function_select)
      `FUNC_STRENGTH: nxt.pulse = cur.strength_live && (cur.step_pos < cur.strength_duty);
      `FUNC_LEVEL: nxt.pulse = (cur.lvl_pos < lvl_thresh);
      default: nxt.pulse = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cur <= '0;
      cur.second_output_function_select <= `RST_FUNC_SEL;
      cur.second_output_level <= `RST_LEVEL;
      cur.passed_level_timeout <= `RST_PASS_TMO;
      cur.signal_strength_hold_time <= `RST_HOLD_TIME;
      cur.io_source_address_match <= `RST_SRC_ADDR;
    end else begin
      cur <= nxt;
    end
  end

  assign o_prdata = cur.prdata;
  assign o_pready = cur.pready;
  assign o_pslverr = cur.pslverr;
  assign o_second_pulse_output = cur.pulse;

  // ----------------------------------------
  // Bus assertions
  // ----------------------------------------
  a_apb_ready: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    setup |=> o_pready ##1 !o_pready)
    else $error("pready timing wrong");

  a_err_with_ready: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_pslverr |-> o_pready)
    else $error("error flag without ready");

  a_bad_addr_err: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    setup && !(i_paddr inside {`OFS_FUNC_SEL, `OFS_LEVEL, `OFS_PASS_TMO, `OFS_HOLD_TIME, `OFS_SRC_ADDR, `OFS_STATUS})
    |=> o_pslverr)
    else $error("unmapped address not refused");

  a_bad_sel_err: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    setup && i_pwrite && i_paddr == `OFS_FUNC_SEL && i_pwdata[1:0] == 2'h3 |=> o_pslverr)
    else $error("selector value three not refused");

  a_bad_sel_kept: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    access && i_pwrite && i_paddr == `OFS_FUNC_SEL && i_pwdata[1:0] == 2'h3
    |=> $stable(cur.second_output_function_select))
    else $error("selector value three written");

  a_sel_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    access && i_pwrite && i_paddr == `OFS_FUNC_SEL && i_pwdata[1:0] != 2'h3
    |=> cur.second_output_function_select == $past(i_pwdata[1:0]))
    else $error("selector write lost");

  a_no_setup_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    setup |=> $stable(cur.second_output_function_select) && $stable(cur.io_source_address_match))
    else $error("write before access phase");

  a_level_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    access && i_pwrite && i_paddr == `OFS_LEVEL && !i_io_packet.valid && !tick
    |=> cur.second_output_level == $past(i_pwdata[9:0]))
    else $error("level write lost");

  a_sel_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.second_output_function_select <= `FUNC_LEVEL)
    else $error("selector out of range");

  // ----------------------------------------
  // Timeout and packet assertions
  // ----------------------------------------
  a_prescale_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !tick |=> cur.prescale == $past(cur.prescale) + 22'h1)
    else $error("prescaler skipped a count");

  a_pass_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !tick && !i_io_packet.valid |=> $stable(cur.pass_cnt))
    else $error("passed timeout moved without tick");

  a_hold_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !tick && !i_rx_packet.valid |=> $stable(cur.hold_cnt))
    else $error("hold counter moved without tick");

  a_level_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_io_packet.valid && i_io_packet.has_second_analog && i_io_packet.src_addr == cur.io_source_address_match
    |=> cur.second_output_level == $past(i_io_packet.second_analog_input))
    else $error("analog value not loaded");

  a_pass_restart: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_io_packet.valid && i_io_packet.src_addr == cur.io_source_address_match && !i_io_packet.has_second_analog
    |=> cur.pass_cnt == $past(cur.passed_level_timeout))
    else $error("timeout not restarted");

  a_pass_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_io_packet.valid && i_io_packet.src_addr == cur.io_source_address_match && i_io_packet.has_second_analog
    && i_io_packet.second_analog_input != 10'h000 |=> cur.pass_cnt == $past(cur.passed_level_timeout))
    else $error("shared timeout not loaded");

  a_zero_stops: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_io_packet.valid && i_io_packet.src_addr == cur.io_source_address_match && i_io_packet.has_second_analog
    && i_io_packet.second_analog_input == 10'h000 |=> cur.pass_cnt == 8'h00)
    else $error("zero level left timer running");

  a_foreign_kept: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_io_packet.valid && i_io_packet.src_addr != cur.io_source_address_match && !tick && !access
    |=> $stable(cur.second_output_level))
    else $error("foreign packet changed level");

  a_pass_expire: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    tick && cur.pass_cnt == 8'h01 && !i_io_packet.valid |=> cur.second_output_level == 10'h000)
    else $error("passed level not cleared");

  a_hold_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rx_packet.valid |=> cur.hold_cnt == $past(cur.signal_strength_hold_time))
    else $error("hold time not reloaded");

  a_rx_live: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rx_packet.valid |=> cur.strength_live)
    else $error("packet did not enable strength");

  a_duty_10db: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rx_packet.valid && i_rx_packet.margin_db == 8'd10 |=> cur.strength_duty == 10'd182)
    else $error("duty at 10 dB wrong");

  a_duty_20db: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rx_packet.valid && i_rx_packet.margin_db == 8'd20 |=> cur.strength_duty == 10'd258)
    else $error("duty at 20 dB wrong");

  a_duty_30db: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rx_packet.valid && i_rx_packet.margin_db == 8'd30 |=> cur.strength_duty == 10'd333)
    else $error("duty at 30 dB wrong");

  a_hold_expire: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    tick && cur.hold_cnt == 8'h01 && cur.signal_strength_hold_time != `HOLD_FOREVER && !i_rx_packet.valid
    |=> !cur.strength_live ##1 !o_second_pulse_output)
    else $error("strength not dropped");

  a_hold_forever: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.strength_live && cur.signal_strength_hold_time == `HOLD_FOREVER |=> cur.strength_live)
    else $error("strength dropped with hold forever");

  // ----------------------------------------
  // Pulse assertions
  // ----------------------------------------
  a_func_off_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.second_output_function_select == `FUNC_DISABLED |=> !o_second_pulse_output)
    else $error("output high while disabled");

  a_duty_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.strength_live |-> cur.strength_duty >= `DUTY_FLOOR && cur.strength_duty <= `STRENGTH_STEPS)
    else $error("strength duty out of range");

  a_step_bound: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.step_pos < `STRENGTH_STEPS)
    else $error("strength step past period");

  a_step_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.step_div != 3'(`STEP_CYCLES - 1) |=> $stable(cur.step_pos))
    else $error("strength step too short");

  a_lvl_bound: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.lvl_pos < 12'(`LEVEL_PERIOD_CYCLES))
    else $error("level position past period");

  a_strength_dark: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.second_output_function_select == `FUNC_STRENGTH && !cur.strength_live |=> !o_second_pulse_output)
    else $error("strength output high without packet");

  a_strength_full: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.second_output_function_select == `FUNC_STRENGTH && cur.strength_live && cur.strength_duty == `STRENGTH_STEPS
    |=> o_second_pulse_output)
    else $error("full strength not high");

  a_level_full: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.second_output_function_select == `FUNC_LEVEL && cur.second_output_level == `LEVEL_FULL
    |=> o_second_pulse_output)
    else $error("full level not high");

  a_level_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur.second_output_function_select == `FUNC_LEVEL && cur.second_output_level == `RST_LEVEL
    |=> !o_second_pulse_output)
    else $error("zero level not low");

endmodule : pwm_rssi_output_control
